// *** include/cmp_ctrl_pkg.sv ***
// Package with the comparator control register map and carrier types.
package cmp_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] comparator_control_addr = 8'h9d;
  localparam logic [7:0] comparator_control_page = 8'h00;
  localparam logic [7:0] comparator_control_reset = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions and synchroniser depth
  // ----------------------------------------------------------------------
  localparam int cmp_enable_pos = 7;
  localparam int output_state_pos = 6;
  localparam int rise_flag_pos = 5;
  localparam int fall_flag_pos = 4;
  localparam int pos_hyst_lsb = 2;
  localparam int neg_hyst_lsb = 0;
  localparam int sync_stages = 2;

  // ----------------------------------------------------------------------
  // Hysteresis encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] hyst_off = 2'h0;
  localparam logic [1:0] hyst_5mv = 2'h1;
  localparam logic [1:0] hyst_10mv = 2'h2;
  localparam logic [1:0] hyst_20mv = 2'h3;

  // Register bus access from the CPU special-function bus.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] page;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_s;

  // Signals driven to the analog comparator.
  typedef struct packed {
    logic enable;
    logic [1:0] pos_hysteresis_sel;
    logic [1:0] neg_hysteresis_sel;
  } analog_ctrl_s;

endpackage

// *** logic/comparator_control_logic.sv ***
// Control and status register logic for an on-chip analog comparator.
`timescale 1ns/10ps
//
// Contract
// [R1] Bit 7 enables the comparator when 1, disables when 0.
// [R2] Bit 6 is read-only live comparator output, 1 when plus exceeds minus.
// [R3] Bit 5 sets on rising output edge; only software clears it.
// [R4] Bit 4 sets on falling output edge; only software clears it.
// [R5] Bits 3:2 select positive hysteresis: off, 5, 10, 20 mV.
// [R6] Bits 1:0 select negative hysteresis with the same encoding.
// [R7] Register lives at address 0x9D, page 0x00; all bits reset to zero.
// [R8] Interrupt request is high while either flag is set and enabled.
// [R9] Edges sampled each clock from synced output; set beats clear.
module comparator_control_logic (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Special-function register bus
  input wire cmp_ctrl_pkg::sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  // Analog comparator
  input wire logic cmp_raw_out,
  output cmp_ctrl_pkg::analog_ctrl_s analog_ctrl,
  // Interrupt
  input wire logic cmp_irq_enable,
  output logic cmp_irq_req
);
  import cmp_ctrl_pkg::*;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Returns true when the request targets the control register.
  function automatic logic hit(input sfr_req_s r);
    return (r.addr == comparator_control_addr) &&
           (r.page == comparator_control_page);
  endfunction

  logic sel_wr;
  logic sel_rd;

  // Qualify strobes with the decoded address.
  assign sel_wr = sfr_req.wr && hit(sfr_req); // see [R7]
  assign sel_rd = sfr_req.rd && hit(sfr_req); // see [R7]

  // ----------------------------------------------------------------------
  // Comparator output synchronisation and edge detection
  // ----------------------------------------------------------------------
  logic cmp_sync;
  logic prev_q;
  logic prev_d;
  logic rise_evt;
  logic fall_evt;

  level_sync u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in(cmp_raw_out),
    .sync_out(cmp_sync)
  );

  // Edge events compare the synced level against last cycle's copy.
  always_comb begin
    prev_d = cmp_sync;
    rise_evt = cmp_sync && !prev_q; // see [R9]
    fall_evt = !cmp_sync && prev_q; // see [R9]
  end

  // Hold the previous synced level.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  logic enable_q;
  logic enable_d;
  logic rise_flag_q;
  logic rise_flag_d;
  logic fall_flag_q;
  logic fall_flag_d;
  logic [1:0] pos_hyst_q;
  logic [1:0] pos_hyst_d;
  logic [1:0] neg_hyst_q;
  logic [1:0] neg_hyst_d;

  // Writes update fields; an edge event wins over a same-cycle clear.
  always_comb begin
    enable_d = enable_q;
    rise_flag_d = rise_flag_q;
    fall_flag_d = fall_flag_q;
    pos_hyst_d = pos_hyst_q;
    neg_hyst_d = neg_hyst_q;
    if (sel_wr) begin
      enable_d = sfr_req.wdata[cmp_enable_pos]; // see [R1]
      rise_flag_d = sfr_req.wdata[rise_flag_pos]; // see [R3]
      fall_flag_d = sfr_req.wdata[fall_flag_pos]; // see [R4]
      pos_hyst_d = sfr_req.wdata[pos_hyst_lsb +: 2]; // see [R5]
      neg_hyst_d = sfr_req.wdata[neg_hyst_lsb +: 2]; // see [R6]
    end
    if (rise_evt) begin
      rise_flag_d = 1'b1; // see [R3] see [R9]
    end
    if (fall_evt) begin
      fall_flag_d = 1'b1; // see [R4] see [R9]
    end
  end

  // Register the fields; everything clears to zero on reset.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      enable_q <= comparator_control_reset[cmp_enable_pos]; // see [R7]
      rise_flag_q <= comparator_control_reset[rise_flag_pos];
      fall_flag_q <= comparator_control_reset[fall_flag_pos];
      pos_hyst_q <= comparator_control_reset[pos_hyst_lsb +: 2];
      neg_hyst_q <= comparator_control_reset[neg_hyst_lsb +: 2];
    end else begin
      enable_q <= enable_d;
      rise_flag_q <= rise_flag_d;
      fall_flag_q <= fall_flag_d;
      pos_hyst_q <= pos_hyst_d;
      neg_hyst_q <= neg_hyst_d;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  // Read data is registered; unselected reads return zero.
  always_comb begin
    rdata_d = 8'h00;
    rvalid_d = sfr_req.rd;
    if (sel_rd) begin
      rdata_d[cmp_enable_pos] = enable_q;
      rdata_d[output_state_pos] = cmp_sync; // see [R2]
      rdata_d[rise_flag_pos] = rise_flag_q;
      rdata_d[fall_flag_pos] = fall_flag_q;
      rdata_d[pos_hyst_lsb +: 2] = pos_hyst_q;
      rdata_d[neg_hyst_lsb +: 2] = neg_hyst_q;
    end
  end

  // Register read answer.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign sfr_rvalid = rvalid_q;

  // ----------------------------------------------------------------------
  // Outputs to the analog side and interrupt
  // ----------------------------------------------------------------------
  // Analog controls come straight from the field flops.
  always_comb begin
    analog_ctrl.enable = enable_q; // see [R1]
    analog_ctrl.pos_hysteresis_sel = pos_hyst_q; // see [R5]
    analog_ctrl.neg_hysteresis_sel = neg_hyst_q; // see [R6]
  end

  // Request follows the flags gated by the outside enable.
  assign cmp_irq_req = cmp_irq_enable &&
                       (rise_flag_q || fall_flag_q); // see [R8]

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_rise_seen;
    !prev_q ##0 cmp_sync;
  endsequence

  sequence s_fall_seen;
    prev_q ##0 !cmp_sync;
  endsequence

  a_enable_follows: assert property ( // see [R1]
    @(posedge core_clk) disable iff (reset)
    sel_wr |=> analog_ctrl.enable == $past(sfr_req.wdata[cmp_enable_pos]))
    else $error("Enable bit did not follow the write.");

  a_state_readback: assert property ( // see [R2]
    @(posedge core_clk) disable iff (reset)
    sel_rd |=> sfr_rdata[output_state_pos] == $past(cmp_sync))
    else $error("Output state bit mismatch on read.");

  a_rise_sets: assert property ( // see [R3]
    @(posedge core_clk) disable iff (reset)
    s_rise_seen |=> rise_flag_q)
    else $error("Rising edge did not set its flag.");

  a_rise_sticky: assert property ( // see [R3]
    @(posedge core_clk) disable iff (reset)
    rise_flag_q && !sel_wr |=> rise_flag_q)
    else $error("Rising flag cleared without a write.");

  a_fall_sets: assert property ( // see [R4]
    @(posedge core_clk) disable iff (reset)
    s_fall_seen |=> fall_flag_q)
    else $error("Falling edge did not set its flag.");

  a_fall_sticky: assert property ( // see [R4]
    @(posedge core_clk) disable iff (reset)
    fall_flag_q && !sel_wr |=> fall_flag_q)
    else $error("Falling flag cleared without a write.");

  a_pos_hyst_wr: assert property ( // see [R5]
    @(posedge core_clk) disable iff (reset)
    sel_wr |=> analog_ctrl.pos_hysteresis_sel ==
      $past(sfr_req.wdata[pos_hyst_lsb +: 2]))
    else $error("Positive hysteresis not written.");

  a_neg_hyst_wr: assert property ( // see [R6]
    @(posedge core_clk) disable iff (reset)
    sel_wr |=> analog_ctrl.neg_hysteresis_sel ==
      $past(sfr_req.wdata[neg_hyst_lsb +: 2]))
    else $error("Negative hysteresis not written.");

  a_reset_zero: assert property ( // see [R7]
    @(posedge core_clk)
    reset |=> {enable_q, rise_flag_q, fall_flag_q, pos_hyst_q,
               neg_hyst_q} == 7'h00)
    else $error("Control fields not zero after reset.");

  a_irq_level: assert property ( // see [R8]
    @(posedge core_clk) disable iff (reset)
    (rise_flag_q || fall_flag_q) && cmp_irq_enable |-> cmp_irq_req)
    else $error("Interrupt request missing.");

  a_irq_quiet: assert property ( // see [R8]
    @(posedge core_clk) disable iff (reset)
    !(cmp_irq_enable && (rise_flag_q || fall_flag_q)) |-> !cmp_irq_req)
    else $error("Interrupt request without an enabled flag.");

  a_set_wins: assert property ( // see [R9]
    @(posedge core_clk) disable iff (reset)
    rise_evt && sel_wr && !sfr_req.wdata[rise_flag_pos] |=> rise_flag_q)
    else $error("Same-cycle clear beat the rising edge.");
endmodule

// *** logic/level_sync.sv ***
// Two-flop synchroniser for an asynchronous level.
`timescale 1ns/10ps
module level_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Level in and out
  input wire logic async_in,
  output logic sync_out
);
  import cmp_ctrl_pkg::*;

  logic [sync_stages-1:0] stage_q;
  logic [sync_stages-1:0] stage_d;

  // ----------------------------------------------------------------------
  // Shift chain
  // ----------------------------------------------------------------------
  // The first stage feeds only the second stage.
  always_comb begin
    stage_d = {stage_q[sync_stages-2:0], async_in};
  end

  // Register the chain.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stage_q <= '0;
    end else begin
      stage_q <= stage_d;
    end
  end

  assign sync_out = stage_q[sync_stages-1];
endmodule

// *** verification/cmp_analog_model.sv ***
// Behavioural analog comparator with selectable hysteresis.
`timescale 1ns/10ps
module cmp_analog_model (
  // Control from the block
  input wire cmp_ctrl_pkg::analog_ctrl_s analog_ctrl,
  // Input voltages in millivolts
  input wire logic signed [15:0] plus_mv,
  input wire logic signed [15:0] minus_mv,
  // Raw comparator output
  output logic cmp_out
);
  import cmp_ctrl_pkg::*;

  // Hysteresis band in millivolts for a select code.
  function automatic int band(logic [1:0] sel);
    case (sel)
      hyst_5mv: return 5;
      hyst_10mv: return 10;
      hyst_20mv: return 20;
      default: return 0;
    endcase
  endfunction

  // A disabled comparator rests low; an enabled one trips past its band.
  initial cmp_out = 1'b0;
  always @(analog_ctrl, plus_mv, minus_mv) begin
    if (!analog_ctrl.enable) begin
      cmp_out = 1'b0;
    end else if (plus_mv >
                 minus_mv + band(analog_ctrl.pos_hysteresis_sel)) begin
      cmp_out = 1'b1;
    end else if (plus_mv <
                 minus_mv - band(analog_ctrl.neg_hysteresis_sel)) begin
      cmp_out = 1'b0;
    end
  end
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the comparator control register block.
`timescale 1ns/10ps
module tb_top;
  import cmp_ctrl_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  sfr_req_s req = '0;
  logic [7:0] rdata;
  logic rvalid;
  logic raw;
  analog_ctrl_s actl;
  logic irq_en = 1'b0;
  logic irq;
  logic signed [15:0] plus_mv = 16'sh384;
  logic signed [15:0] minus_mv = 16'sh3e8;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] rv;

  comparator_control_logic dut_u (.core_clk(core_clk), .reset(reset),
    .sfr_req(req), .sfr_rdata(rdata), .sfr_rvalid(rvalid),
    .cmp_raw_out(raw), .analog_ctrl(actl), .cmp_irq_enable(irq_en),
    .cmp_irq_req(irq));
  cmp_analog_model model_u (.analog_ctrl(actl), .plus_mv(plus_mv),
    .minus_mv(minus_mv), .cmp_out(raw));

  // Clock and a cycle ceiling that cuts a hang short.
  initial forever #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      results();
    end
  end

  // Compares one value and counts the outcome.
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle write strobe, entered at a falling edge; an idle cycle
  // follows so that the next strobe never rises in the same step.
  task automatic wr(logic [7:0] a, logic [7:0] p, logic [7:0] d);
    req = '{addr: a, page: p, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge core_clk);
    req.wr = 1'b0;
    @(negedge core_clk);
  endtask

  // One-cycle read strobe; the answer stands for the next cycle only.
  task automatic rd(logic [7:0] a, logic [7:0] p, output logic [7:0] d);
    req = '{addr: a, page: p, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge core_clk);
    req.rd = 1'b0;
    check("rvalid", {7'h00, rvalid}, 8'h01);
    d = rdata;
    @(negedge core_clk);
    check("rvalid end", {7'h00, rvalid}, 8'h00);
  endtask

  // Reset value and refused addresses and pages.
  task automatic t_map();
    rd(8'h9d, 8'h00, rv);
    check("reset", rv, comparator_control_reset);
    check("actl", {3'h0, actl}, 8'h00);
    wr(8'h9e, 8'h00, 8'hff);
    wr(8'h9d, 8'h01, 8'hff);
    rd(8'h9e, 8'h00, rv);
    check("unmapped", rv, 8'h00);
    rd(8'h9d, 8'h00, rv);
    check("ignored", rv, 8'h00);
  endtask

  // Every hysteresis code, enable on and off, bit 6 write ignored.
  task automatic t_fields();
    for (int i = 0; i < 4; i++) begin
      wr(8'h9d, 8'h00, 8'hc0 | 8'(i << 2) | 8'(3 - i));
      rd(8'h9d, 8'h00, rv);
      check("fields", rv, 8'h80 | 8'(i << 2) | 8'(3 - i));
      check("pos", {6'h0, actl.pos_hysteresis_sel}, 8'(i));
      check("neg", {6'h0, actl.neg_hysteresis_sel}, 8'(3 - i));
      check("en", {7'h0, actl.enable}, 8'h01);
    end
    wr(8'h9d, 8'h00, 8'h00);
    check("dis", {7'h0, actl.enable}, 8'h00);
  endtask

  // Rising and falling flags, sticky until cleared, and the request.
  task automatic t_edges();
    wr(8'h9d, 8'h00, 8'h80);
    plus_mv = 16'sh44c;
    repeat (4) @(negedge core_clk);
    rd(8'h9d, 8'h00, rv);
    check("rise", rv, 8'he0);
    check("irq off", {7'h0, irq}, 8'h00);
    irq_en = 1'b1;
    @(negedge core_clk);
    check("irq on", {7'h0, irq}, 8'h01);
    plus_mv = 16'sh384;
    repeat (4) @(negedge core_clk);
    rd(8'h9d, 8'h00, rv);
    check("fall", rv, 8'hb0);
    wr(8'h9d, 8'h00, 8'h80);
    rd(8'h9d, 8'h00, rv);
    check("clear", rv, 8'h80);
    check("irq clr", {7'h0, irq}, 8'h00);
  endtask

  // A clear landing on the edge that sets the flag leaves it set.
  task automatic t_set_wins();
    plus_mv = 16'sh44c;
    repeat (2) @(negedge core_clk);
    wr(8'h9d, 8'h00, 8'h80);
    rd(8'h9d, 8'h00, rv);
    check("set wins", rv, 8'he0);
  endtask

  // Largest bands: small swings do not trip, large ones do.
  task automatic t_hyst();
    plus_mv = 16'sh384;
    repeat (4) @(negedge core_clk);
    wr(8'h9d, 8'h00, 8'h8f);
    plus_mv = 16'sh3f2;
    repeat (4) @(negedge core_clk);
    rd(8'h9d, 8'h00, rv);
    check("in band hi", rv, 8'h8f);
    plus_mv = 16'sh406;
    repeat (4) @(negedge core_clk);
    plus_mv = 16'sh3de;
    repeat (4) @(negedge core_clk);
    rd(8'h9d, 8'h00, rv);
    check("in band lo", rv, 8'hef);
    plus_mv = 16'sh3ca;
    repeat (4) @(negedge core_clk);
    rd(8'h9d, 8'h00, rv);
    check("past band", rv, 8'hbf);
  endtask

  // A reset in mid-run returns every field, output and request to zero.
  task automatic t_reset();
    wr(8'h9d, 8'h00, 8'hbf);
    check("irq set", {7'h0, irq}, 8'h01);
    reset = 1'b1;
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    check("irq rst", {7'h0, irq}, 8'h00);
    check("actl rst", {3'h0, actl}, 8'h00);
    rd(8'h9d, 8'h00, rv);
    check("rst value", rv, comparator_control_reset);
  endtask

  // Prints the verdict and ends the run.
  task automatic results();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    t_map();
    t_fields();
    t_edges();
    t_set_wins();
    t_hyst();
    t_reset();
    results();
  end
endmodule
